// file: ufb_pkg.sv
package ufb_pkg;
    // queue and bus shape
    localparam int unsigned DEPTH = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_TOP = 4;
    // register indexes, byte address is index times four
    localparam logic [2:0] R_DATA = 3'h0;
    localparam logic [2:0] R_MASK = 3'h1;
    localparam logic [2:0] R_QCTL = 3'h2;
    localparam logic [2:0] R_LCTL = 3'h3;
    localparam logic [2:0] R_MCTL = 3'h4;
    localparam logic [2:0] R_LSTAT = 3'h5;
    localparam logic [2:0] R_MSTAT = 3'h6;
    localparam logic [2:0] R_SCRATCH = 3'h7;
    // queue_ctrl fields
    localparam int QC_EN = 0;
    localparam int QC_RXRST = 1;
    localparam int QC_TXRST = 2;
    localparam int QC_DMA = 3;
    localparam int QC_TRIG = 6;
    // irq_mask_reg fields
    localparam int IM_RX = 0;
    localparam int IM_TX = 1;
    localparam int IM_LINE = 2;
    localparam int IM_MODEM = 3;
    // line_ctrl fields
    localparam int LC_WL = 0;
    localparam int LC_BREAK = 6;
    localparam int LC_DLAB = 7;
    // modem_ctrl fields
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_OUTA = 2;
    localparam int MC_OUTB = 3;
    localparam int MC_LOOP = 4;
    // reset values
    localparam logic [7:0] SCRATCH_RST = 8'hff;
    // receive trigger levels
    localparam logic [4:0] TRIG_L0 = 5'h01;
    localparam logic [4:0] TRIG_L1 = 5'h04;
    localparam logic [4:0] TRIG_L2 = 5'h08;
    localparam logic [4:0] TRIG_L3 = 5'h0e;
    // bit timing in x16 ticks
    localparam int TICKS_PER_BIT = 16;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] START_CHECK = 4'h7;
    localparam logic [3:0] WL_BASE = 4'h5;
    localparam int TO_MULT = 4;
    localparam int TO_ADD = 12;
    // interrupt status codes
    localparam logic [3:0] IC_NONE = 4'h1;
    localparam logic [3:0] IC_LINE = 4'h6;
    localparam logic [3:0] IC_RXDATA = 4'h4;
    localparam logic [3:0] IC_TIMEOUT = 4'hc;
    localparam logic [3:0] IC_TXEMPTY = 4'h2;
    localparam logic [3:0] IC_MODEM = 4'h0;

    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA = 4'b0100,
        TX_STOP = 4'b1000
    } ufb_tx_st_t;

    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } ufb_rx_st_t;
endpackage : ufb_pkg

// file: ufb_uart.sv
`timescale 1ns/10ps
// How it works
// - two 16-entry queues, switched into use by queue_ctrl bit 0
// - receive trigger level is programmable; transmit side has none
// - time-out interrupt when data sits unread below the trigger level
// - data-ready ranks above time-out, both enabled by mask bit 0
// - data interrupt once queued count reaches the trigger level
// - no time-out while the receive queue is empty
// - time-out counter restarts at stop-bit middle and on every rx_hold read
// - time-out length is four times word length plus twelve bit times
// - baud generator divides the input clock by divisor 1 to 65535 into the 16x tick
// - rate output runs at sixteen times the bit rate
// - divisor built from low byte and divisor_high byte
// - queue_ctrl bit 3 selects block mode for both ready pins
// - receive-ready pin: empty level in single mode, rises on empty in block mode
// - block mode: receive-ready falls at trigger level or time-out
// - transmit-ready: empty level in single mode, full level in block mode
// - loop-back detaches modem inputs and holds the four modem output pins inactive
// - loop-back feeds serializer output into the receiver internally
// - loop-back drives status inputs from terminal-ready, request, user outputs
// - interrupts keep working in loop-back, still masked normally
// - serial output pin held high during loop-back
// - divisor bytes reachable only while line_ctrl bit 7 is set
module ufb_uart #(
    parameter int unsigned DEPTH = ufb_pkg::DEPTH
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    // apb slave
    input wire logic [ufb_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial line
    input wire logic rx_pin,
    output logic tx_pin,
    // modem inputs, active low
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic carrier_detect_in_n,
    input wire logic phone_bell_in_n,
    // modem outputs, active low
    output logic dtr_n,
    output logic rts_n,
    output logic user_out_a_n,
    output logic user_out_b_n,
    // rate clock
    input wire logic osc_in,
    output logic rate_x16_out_n,
    // events and block-transfer handshakes
    output logic irq_out,
    output logic rx_ready_n,
    output logic tx_ready_n
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;

    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        logic [3:0] m_s1;
        logic [3:0] m_s2;
        logic [3:0] m_prev;
        logic osc_s1;
        logic osc_s2;
        logic osc_prev;
        logic [15:0] bcnt;
        logic rate_n;
        logic [DEPTH-1:0][7:0] tx_q;
        logic [PW-1:0] tx_rd;
        logic [PW-1:0] tx_wr;
        logic [CW-1:0] tx_cnt;
        logic [DEPTH-1:0][7:0] rx_q;
        logic [PW-1:0] rx_rd;
        logic [PW-1:0] rx_wr;
        logic [CW-1:0] rx_cnt;
        logic [3:0] mask;
        logic q_en;
        logic q_dma;
        logic [1:0] q_trig;
        logic [7:0] lctl;
        logic [4:0] mctl;
        logic [7:0] scratch;
        logic [15:0] div;
        logic [3:0] m_delta;
        logic overrun;
        logic frame_err;
        ufb_pkg::ufb_tx_st_t tx_st;
        logic [7:0] tx_sh;
        logic [2:0] tx_bit;
        logic [3:0] tx_tc;
        logic tx_line;
        ufb_pkg::ufb_rx_st_t rx_st;
        logic [7:0] rx_sh;
        logic [2:0] rx_bit;
        logic [3:0] rx_tc;
        logic [9:0] to_cnt;
        logic to_flag;
        logic rx_rdy_n;
        logic [31:0] prdata;
        logic perr;
        logic pok;
    } ufb_state_t;

    localparam ufb_state_t RST_ST = '{
        rx_s1: 1'b1, rx_s2: 1'b1, m_s1: 4'hf, m_s2: 4'hf,
        scratch: ufb_pkg::SCRATCH_RST, tx_st: ufb_pkg::TX_IDLE,
        rx_st: ufb_pkg::RX_IDLE, tx_line: 1'b1, rx_rdy_n: 1'b1,
        rate_n: 1'b1, default: '0
    };

    ufb_state_t st_ff;
    ufb_state_t nxt_st;

    // shared status derived from registered state
    logic dlab;
    logic loop;
    logic [CW-1:0] lim;
    logic [4:0] trig;
    logic rx_hit;
    logic [3:0] m_now;
    logic [3:0] icode;

    assign dlab = st_ff.lctl[ufb_pkg::LC_DLAB];
    assign loop = st_ff.mctl[ufb_pkg::MC_LOOP];
    assign lim = st_ff.q_en ? CW'(DEPTH) : CW'(1);
    assign rx_hit = 5'(st_ff.rx_cnt) >= trig;
    // cts, dsr, ri, cd as active-high levels
    assign m_now = loop ? {st_ff.mctl[ufb_pkg::MC_OUTA], st_ff.mctl[ufb_pkg::MC_OUTB],
                           st_ff.mctl[ufb_pkg::MC_RTS], st_ff.mctl[ufb_pkg::MC_DTR]}
                        : ~st_ff.m_s2;

    // trigger level selection, level one when queues are off
    always_comb begin
        case (st_ff.q_trig)
            2'h0: trig = ufb_pkg::TRIG_L0;
            2'h1: trig = ufb_pkg::TRIG_L1;
            2'h2: trig = ufb_pkg::TRIG_L2;
            default: trig = ufb_pkg::TRIG_L3;
        endcase
        if (!st_ff.q_en) begin
            trig = ufb_pkg::TRIG_L0;
        end
    end

    // interrupt priority; masks apply in loop-back as well
    always_comb begin
        if (st_ff.mask[ufb_pkg::IM_LINE] && (st_ff.overrun || st_ff.frame_err)) begin
            icode = ufb_pkg::IC_LINE;
        end else if (st_ff.mask[ufb_pkg::IM_RX] && rx_hit) begin
            icode = ufb_pkg::IC_RXDATA;
        end else if (st_ff.mask[ufb_pkg::IM_RX] && st_ff.to_flag) begin
            icode = ufb_pkg::IC_TIMEOUT;
        end else if (st_ff.mask[ufb_pkg::IM_TX] && st_ff.tx_cnt == '0) begin
            icode = ufb_pkg::IC_TXEMPTY;
        end else if (st_ff.mask[ufb_pkg::IM_MODEM] && st_ff.m_delta != 4'h0) begin
            icode = ufb_pkg::IC_MODEM;
        end else begin
            icode = ufb_pkg::IC_NONE;
        end
    end

    // next-state logic for the whole block
    always_comb begin
        logic tick;
        logic mapped;
        logic fire;
        logic wr;
        logic rd;
        logic [2:0] idx;
        logic [7:0] rdv;
        logic [16:0] bnext;
        logic [3:0] wl;
        logic [9:0] to_lim;
        logic rx_in;
        logic push_rx;
        logic pop_rx;
        logic push_tx;
        logic pop_tx;
        logic stop_mid;
        logic clr_rx;
        logic clr_tx;
        logic [7:0] rx_word;
        tick = 1'b0;
        mapped = 1'b0;
        fire = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        idx = 3'h0;
        bnext = 17'h0;
        wl = 4'h0;
        to_lim = 10'h000;
        rx_in = 1'b1;
        pop_rx = 1'b0;
        push_tx = 1'b0;
        push_rx = 1'b0;
        pop_tx = 1'b0;
        stop_mid = 1'b0;
        clr_rx = 1'b0;
        clr_tx = 1'b0;
        rx_word = 8'h00;
        rdv = 8'h00;
        nxt_st = st_ff;

        // two-stage synchronisers for pins and the oscillator input
        nxt_st.rx_s1 = rx_pin;
        nxt_st.rx_s2 = st_ff.rx_s1;
        nxt_st.m_s1 = {carrier_detect_in_n, phone_bell_in_n, dsr_n, cts_n};
        nxt_st.m_s2 = st_ff.m_s1;
        nxt_st.osc_s1 = osc_in;
        nxt_st.osc_s2 = st_ff.osc_s1;
        nxt_st.osc_prev = st_ff.osc_s2;

        // baud divider, one tick per divisor count of oscillator edges
        bnext = 17'(st_ff.bcnt) + 17'h1;
        if (st_ff.osc_s2 && !st_ff.osc_prev) begin
            if (bnext >= 17'(st_ff.div)) begin
                nxt_st.bcnt = 16'h0;
                tick = 1'b1;
            end else begin
                nxt_st.bcnt = bnext[15:0];
            end
        end
        // low half of each tick period, follows oscillator at divisor one
        nxt_st.rate_n = (st_ff.div <= 16'h1) ? st_ff.osc_s2 : (nxt_st.bcnt < (st_ff.div >> 1));

        wl = ufb_pkg::WL_BASE + {2'h0, st_ff.lctl[ufb_pkg::LC_WL +: 2]};
        to_lim = 10'((ufb_pkg::TO_MULT * int'(wl) + ufb_pkg::TO_ADD) * ufb_pkg::TICKS_PER_BIT);

        // apb decode; prdata is captured while the request is pending
        idx = paddr[ufb_pkg::IDX_TOP:ufb_pkg::IDX_LSB];
        mapped = (paddr[ufb_pkg::ADDR_W-1:ufb_pkg::IDX_TOP+1] == '0) && (paddr[1:0] == 2'h0);
        fire = psel && penable && st_ff.pok;
        wr = fire && pwrite && mapped && pstrb[0];
        rd = fire && !pwrite && mapped;

        // read mux
        case (idx)
            ufb_pkg::R_DATA: rdv = dlab ? st_ff.div[7:0] : st_ff.rx_q[st_ff.rx_rd];
            ufb_pkg::R_MASK: rdv = dlab ? st_ff.div[15:8] : {4'h0, st_ff.mask};
            ufb_pkg::R_QCTL: rdv = {st_ff.q_en, st_ff.q_en, 2'h0, icode};
            ufb_pkg::R_LCTL: rdv = st_ff.lctl;
            ufb_pkg::R_MCTL: rdv = {3'h0, st_ff.mctl};
            ufb_pkg::R_LSTAT: rdv = {1'b0, st_ff.tx_cnt == '0 && st_ff.tx_st == ufb_pkg::TX_IDLE,
                                     st_ff.tx_cnt == '0, 1'b0, st_ff.frame_err, 1'b0,
                                     st_ff.overrun, st_ff.rx_cnt != '0};
            ufb_pkg::R_MSTAT: rdv = {m_now, st_ff.m_delta};
            default: rdv = st_ff.scratch;
        endcase
        nxt_st.prdata = fire ? st_ff.prdata : {24'h0, mapped ? rdv : 8'h00};
        nxt_st.perr = fire ? st_ff.perr : !mapped;
        nxt_st.pok = psel && !fire;

        pop_rx = rd && idx == ufb_pkg::R_DATA && !dlab && st_ff.rx_cnt != '0;
        push_tx = wr && idx == ufb_pkg::R_DATA && !dlab && st_ff.tx_cnt < lim;

        // register writes
        if (wr) begin
            case (idx)
                ufb_pkg::R_DATA: begin
                    if (dlab) begin
                        nxt_st.div[7:0] = pwdata[7:0];
                    end
                end
                ufb_pkg::R_MASK: begin
                    if (dlab) begin
                        nxt_st.div[15:8] = pwdata[7:0];
                    end else begin
                        nxt_st.mask = pwdata[3:0];
                    end
                end
                ufb_pkg::R_QCTL: begin
                    nxt_st.q_en = pwdata[ufb_pkg::QC_EN];
                    nxt_st.q_dma = pwdata[ufb_pkg::QC_DMA];
                    nxt_st.q_trig = pwdata[ufb_pkg::QC_TRIG +: 2];
                    clr_rx = pwdata[ufb_pkg::QC_RXRST] || (pwdata[ufb_pkg::QC_EN] != st_ff.q_en);
                    clr_tx = pwdata[ufb_pkg::QC_TXRST] || (pwdata[ufb_pkg::QC_EN] != st_ff.q_en);
                end
                ufb_pkg::R_LCTL: nxt_st.lctl = pwdata[7:0];
                ufb_pkg::R_MCTL: nxt_st.mctl = pwdata[4:0];
                ufb_pkg::R_SCRATCH: nxt_st.scratch = pwdata[7:0];
                default: ;
            endcase
        end

        // transmitter, sixteen ticks per bit
        if (tick) begin
            nxt_st.tx_tc = st_ff.tx_tc + 4'h1;
            case (st_ff.tx_st)
                ufb_pkg::TX_IDLE: begin
                    nxt_st.tx_tc = 4'h0;
                    if (st_ff.tx_cnt != '0) begin
                        pop_tx = 1'b1;
                        nxt_st.tx_sh = st_ff.tx_q[st_ff.tx_rd];
                        nxt_st.tx_line = 1'b0;
                        nxt_st.tx_st = ufb_pkg::TX_START;
                    end
                end
                ufb_pkg::TX_START: begin
                    if (st_ff.tx_tc == ufb_pkg::TICK_LAST) begin
                        nxt_st.tx_line = st_ff.tx_sh[0];
                        nxt_st.tx_bit = 3'h0;
                        nxt_st.tx_st = ufb_pkg::TX_DATA;
                    end
                end
                ufb_pkg::TX_DATA: begin
                    if (st_ff.tx_tc == ufb_pkg::TICK_LAST) begin
                        nxt_st.tx_sh = st_ff.tx_sh >> 1;
                        nxt_st.tx_bit = st_ff.tx_bit + 3'h1;
                        nxt_st.tx_line = st_ff.tx_sh[1];
                        if (4'(st_ff.tx_bit) == wl - 4'h1) begin
                            nxt_st.tx_line = 1'b1;
                            nxt_st.tx_st = ufb_pkg::TX_STOP;
                        end
                    end
                end
                ufb_pkg::TX_STOP: begin
                    if (st_ff.tx_tc == ufb_pkg::TICK_LAST) begin
                        nxt_st.tx_st = ufb_pkg::TX_IDLE;
                    end
                end
                default: nxt_st.tx_st = ufb_pkg::TX_IDLE;
            endcase
        end

        // receiver, samples at bit centres
        rx_in = loop ? st_ff.tx_line : st_ff.rx_s2;
        if (tick) begin
            nxt_st.rx_tc = st_ff.rx_tc + 4'h1;
            case (st_ff.rx_st)
                ufb_pkg::RX_IDLE: begin
                    nxt_st.rx_tc = 4'h0;
                    if (!rx_in) begin
                        nxt_st.rx_st = ufb_pkg::RX_START;
                    end
                end
                ufb_pkg::RX_START: begin
                    if (st_ff.rx_tc == ufb_pkg::START_CHECK) begin
                        nxt_st.rx_tc = 4'h0;
                        nxt_st.rx_bit = 3'h0;
                        nxt_st.rx_st = rx_in ? ufb_pkg::RX_IDLE : ufb_pkg::RX_DATA;
                    end
                end
                ufb_pkg::RX_DATA: begin
                    if (st_ff.rx_tc == ufb_pkg::TICK_LAST) begin
                        nxt_st.rx_sh = {rx_in, st_ff.rx_sh[7:1]};
                        nxt_st.rx_bit = st_ff.rx_bit + 3'h1;
                        if (4'(st_ff.rx_bit) == wl - 4'h1) begin
                            nxt_st.rx_st = ufb_pkg::RX_STOP;
                        end
                    end
                end
                ufb_pkg::RX_STOP: begin
                    if (st_ff.rx_tc == ufb_pkg::TICK_LAST) begin
                        stop_mid = 1'b1;
                        rx_word = st_ff.rx_sh >> (4'h8 - wl);
                        nxt_st.frame_err = st_ff.frame_err || !rx_in;
                        if (st_ff.rx_cnt < lim) begin
                            push_rx = 1'b1;
                        end else begin
                            nxt_st.overrun = 1'b1;
                        end
                        nxt_st.rx_st = ufb_pkg::RX_IDLE;
                    end
                end
                default: nxt_st.rx_st = ufb_pkg::RX_IDLE;
            endcase
        end

        // line and modem status; new events win over read-clear
        if (rd && idx == ufb_pkg::R_LSTAT) begin
            nxt_st.overrun = 1'b0;
            nxt_st.frame_err = 1'b0;
            if (stop_mid && !push_rx) begin
                nxt_st.overrun = 1'b1;
            end
            if (stop_mid && !rx_in) begin
                nxt_st.frame_err = 1'b1;
            end
        end
        nxt_st.m_prev = m_now;
        nxt_st.m_delta = ((rd && idx == ufb_pkg::R_MSTAT) ? 4'h0 : st_ff.m_delta)
                       | {m_now[3] ^ st_ff.m_prev[3], st_ff.m_prev[2] & !m_now[2],
                          m_now[1:0] ^ st_ff.m_prev[1:0]};

        // queue storage and counts
        if (push_rx) begin
            nxt_st.rx_q[st_ff.rx_wr] = rx_word;
            nxt_st.rx_wr = PW'((32'(st_ff.rx_wr) + 32'd1) % DEPTH);
        end
        if (pop_rx) begin
            nxt_st.rx_rd = PW'((32'(st_ff.rx_rd) + 32'd1) % DEPTH);
        end
        nxt_st.rx_cnt = st_ff.rx_cnt + CW'(push_rx) - CW'(pop_rx);
        if (push_tx) begin
            nxt_st.tx_q[st_ff.tx_wr] = pwdata[7:0];
            nxt_st.tx_wr = PW'((32'(st_ff.tx_wr) + 32'd1) % DEPTH);
        end
        if (pop_tx) begin
            nxt_st.tx_rd = PW'((32'(st_ff.tx_rd) + 32'd1) % DEPTH);
        end
        nxt_st.tx_cnt = st_ff.tx_cnt + CW'(push_tx) - CW'(pop_tx);

        // receive idle time-out
        if (pop_rx || stop_mid) begin
            nxt_st.to_cnt = 10'h000;
        end else if (tick && st_ff.rx_cnt != '0 && st_ff.to_cnt < to_lim) begin
            nxt_st.to_cnt = st_ff.to_cnt + 10'h001;
        end
        if (pop_rx || st_ff.rx_cnt == '0) begin
            nxt_st.to_flag = 1'b0;
        end else if (st_ff.to_cnt >= to_lim && !rx_hit && !stop_mid) begin
            nxt_st.to_flag = 1'b1;
        end

        // block-mode receive-ready edges
        if (st_ff.rx_cnt == '0) begin
            nxt_st.rx_rdy_n = 1'b1;
        end else if (rx_hit || st_ff.to_flag) begin
            nxt_st.rx_rdy_n = 1'b0;
        end

        // queue flushes from queue_ctrl
        if (clr_rx) begin
            nxt_st.rx_rd = '0;
            nxt_st.rx_wr = '0;
            nxt_st.rx_cnt = '0;
            nxt_st.to_flag = 1'b0;
            nxt_st.to_cnt = 10'h000;
        end
        if (clr_tx) begin
            nxt_st.tx_rd = '0;
            nxt_st.tx_wr = '0;
            nxt_st.tx_cnt = '0;
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= RST_ST;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // outputs
    assign prdata = st_ff.prdata;
    assign pslverr = st_ff.perr;
    assign pready = psel && penable && ce && st_ff.pok;
    assign tx_pin = loop || (st_ff.tx_line && !st_ff.lctl[ufb_pkg::LC_BREAK]);
    assign dtr_n = loop || !st_ff.mctl[ufb_pkg::MC_DTR];
    assign rts_n = loop || !st_ff.mctl[ufb_pkg::MC_RTS];
    assign user_out_a_n = loop || !st_ff.mctl[ufb_pkg::MC_OUTA];
    assign user_out_b_n = loop || !st_ff.mctl[ufb_pkg::MC_OUTB];
    assign rate_x16_out_n = st_ff.rate_n;
    assign irq_out = !icode[0];
    assign rx_ready_n = st_ff.q_dma ? st_ff.rx_rdy_n : (st_ff.rx_cnt == '0);
    assign tx_ready_n = st_ff.q_dma ? (st_ff.tx_cnt == lim) : (st_ff.tx_cnt != '0);
endmodule : ufb_uart

// file: ufb_chk.sv
`timescale 1ns/10ps
module ufb_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    // apb
    input wire logic [ufb_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // line and modem outputs
    input wire logic tx_pin,
    input wire logic dtr_n,
    input wire logic rts_n,
    input wire logic user_out_a_n,
    input wire logic user_out_b_n,
    // events
    input wire logic irq_out,
    input wire logic rx_ready_n,
    input wire logic tx_ready_n
);
    logic done, bad, wr_ok, loop_ff, dlab_ff;
    logic [3:0] mask_ff;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // completed transfer and decode
    assign done = psel && penable && pready;
    assign bad = (paddr[7:5] != 3'h0) || (paddr[1:0] != 2'h0);
    assign wr_ok = done && !bad && pwrite && pstrb[0];
    // shadow of loop, dlab and mask bits
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            loop_ff <= 1'b0;
            dlab_ff <= 1'b0;
            mask_ff <= 4'h0;
        end else if (wr_ok) begin
            if (paddr[4:2] == ufb_pkg::R_MCTL) loop_ff <= pwdata[ufb_pkg::MC_LOOP];
            if (paddr[4:2] == ufb_pkg::R_LCTL) dlab_ff <= pwdata[ufb_pkg::LC_DLAB];
            if (paddr[4:2] == ufb_pkg::R_MASK && !dlab_ff) mask_ff <= pwdata[3:0];
        end
    end
    AST_PREADY_QUAL: assert property (pready |-> psel && penable && ce) else $error("pready outside access");
    AST_ZERO_WAIT: assert property ($rose(penable) && psel && ce && $past(ce) |-> pready)
        else $error("access not answered at once");
    AST_SLVERR: assert property (done && bad |-> pslverr) else $error("unmapped access without error");
    AST_UNMAP_ZERO: assert property (done && bad && !pwrite |-> prdata == 32'h0) else $error("unmapped read not zero");
    AST_RDATA_UPPER: assert property (done |-> prdata[31:8] == 24'h0) else $error("read upper bits not zero");
    AST_TX_LOOP: assert property (loop_ff && $past(loop_ff) |-> tx_pin) else $error("tx low in loop");
    AST_MODEM_LOOP: assert property (loop_ff && $past(loop_ff) |-> dtr_n && rts_n && user_out_a_n && user_out_b_n)
        else $error("modem outputs active in loop");
    AST_IRQ_MASK: assert property ((mask_ff == 4'h0)[*3] |-> !irq_out) else $error("irq while masked");
    AST_RESET_LEVELS: assert property ($rose(resetn) |-> tx_pin && rx_ready_n && !tx_ready_n && !irq_out)
        else $error("bad levels after reset");
    // main scenarios
    COV_LOOP: cover property (loop_ff && irq_out);
    COV_RX_READY_N: cover property ($fell(rx_ready_n));
    COV_ERR: cover property (done && pslverr);
endmodule : ufb_chk

// file: ufb_peer.sv
`timescale 1ns/10ps
module ufb_peer (
    // oscillator and serial line
    output logic osc_in,
    output logic rx_pin,
    // modem status lines, active low
    output logic cts_n,
    output logic dsr_n,
    output logic carrier_detect_in_n,
    output logic phone_bell_in_n
);
    // free-running oscillator, 40 ns period, slow enough for the 2ff sync
    always begin
        osc_in = 1'b0;
        #20;
        osc_in = 1'b1;
        #20;
    end
    // idle line and inactive modem lines
    assign rx_pin = 1'b1;
    assign cts_n = 1'b1;
    assign dsr_n = 1'b1;
    assign carrier_detect_in_n = 1'b1;
    assign phone_bell_in_n = 1'b1;
endmodule : ufb_peer

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
    logic sys_clk = 0, resetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, q;
    logic [3:0] pstrb = 4'hf;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, rx_pin, tx_pin, cts_n, dsr_n, carrier_detect_in_n, phone_bell_in_n;
    wire logic dtr_n, rts_n, user_out_a_n, user_out_b_n, osc_in, rate_x16_out_n, irq_out, rx_ready_n, tx_ready_n;
    int errors = 0, tests_run = 0;
    // 200 mhz clock
    always #2.5 sys_clk = ~sys_clk;
    ufb_uart uut (.sys_clk, .resetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .rx_pin, .tx_pin, .cts_n, .dsr_n, .carrier_detect_in_n, .phone_bell_in_n, .dtr_n, .rts_n,
        .user_out_a_n, .user_out_b_n, .osc_in, .rate_x16_out_n, .irq_out, .rx_ready_n, .tx_ready_n);
    ufb_peer peer (.osc_in, .rx_pin, .cts_n, .dsr_n, .carrier_detect_in_n, .phone_bell_in_n);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, held until pready is seen
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        if (n >= 50) chk(32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : xfer
    task wr(input logic [2:0] i, input logic [7:0] d);
        xfer(1'b1, {3'h0, i, 2'h0}, d);
    endtask : wr
    task rd(input logic [2:0] i, input logic [7:0] x);
        xfer(1'b0, {3'h0, i, 2'h0}, 8'h00);
        chk(q, {24'h0, x});
    endtask : rd
    task final_report;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // watchdog
    initial begin
        #200000;
        errors++;
        final_report;
    end
    // main sequence
    initial begin
        int n;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        chk(tx_ready_n, 0);
        chk(rx_ready_n, 1);
        rd(ufb_pkg::R_SCRATCH, 8'hff);
        xfer(1'b0, 8'h21, 8'h00);
        chk({31'h0, e}, 1);
        wr(ufb_pkg::R_LCTL, 8'h83);
        wr(ufb_pkg::R_MASK, 8'h12);
        wr(ufb_pkg::R_DATA, 8'h01); // divisor 1 for the fastest rate
        rd(ufb_pkg::R_MASK, 8'h12);
        rd(ufb_pkg::R_DATA, 8'h01);
        wr(ufb_pkg::R_MASK, 8'h00);
        wr(ufb_pkg::R_LCTL, 8'h03);
        // rate output follows the oscillator at divisor one
        repeat (2) @(negedge rate_x16_out_n);
        q = 32'($time);
        @(negedge rate_x16_out_n);
        chk(32'($time) - q, 32'd40);
        wr(ufb_pkg::R_MASK, 8'h01);
        rd(ufb_pkg::R_MASK, 8'h01);
        wr(ufb_pkg::R_QCTL, 8'h01);
        rd(ufb_pkg::R_QCTL, 8'hc1);
        // loop-back with all control bits set
        wr(ufb_pkg::R_MCTL, 8'h1f);
        repeat (4) @(posedge sys_clk);
        xfer(1'b0, {3'h0, ufb_pkg::R_MSTAT, 2'h0}, 8'h00);
        chk(q & 32'hf0, 32'hf0);
        chk(tx_pin, 1);
        wr(ufb_pkg::R_DATA, 8'ha5);
        for (n = 0; n < 4000 && rx_ready_n !== 1'b0; n++) @(posedge sys_clk);
        chk(rx_ready_n, 0);
        chk(irq_out, 1);
        rd(ufb_pkg::R_QCTL, 8'hc4);
        rd(ufb_pkg::R_DATA, 8'ha5);
        chk(rx_ready_n, 1);
        // block mode, trigger 4, one byte waits for the time-out
        wr(ufb_pkg::R_QCTL, 8'h49);
        chk(tx_ready_n, 0);
        wr(ufb_pkg::R_DATA, 8'h3c);
        repeat (1500) @(posedge sys_clk);
        rd(ufb_pkg::R_LSTAT, 8'h61);
        chk(rx_ready_n, 1);
        repeat (4500) @(posedge sys_clk);
        chk(irq_out, 0);
        for (n = 0; n < 2000 && irq_out !== 1'b1; n++) @(posedge sys_clk);
        chk(irq_out, 1);
        rd(ufb_pkg::R_QCTL, 8'hcc);
        chk(rx_ready_n, 0);
        rd(ufb_pkg::R_DATA, 8'h3c);
        repeat (2) @(posedge sys_clk);
        chk(irq_out, 0);
        chk(rx_ready_n, 1);
        final_report;
    end
endmodule : testbench
bind ufb_uart ufb_chk u_chk (.sys_clk, .resetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .tx_pin, .dtr_n, .rts_n, .user_out_a_n, .user_out_b_n, .irq_out, .rx_ready_n, .tx_ready_n);
